// ---- dv/irq_slice_checker_asserts.sv ----
module irq_slice_checker
  import irq_slice_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        dac_ch2_req_in,
  input wire logic        dac_ch1_req_in,
  input wire logic        charge_time_unit_req_in,
  input wire logic        voltage_detect_req_in,
  input wire logic        uart_b_error_req_in,
  input wire logic        uart_a_error_req_in,
  input wire logic        lowpower_wake_req_in,
  input wire logic [5:0]  periph_req_out,
  input wire logic        wake_req_out,
  input wire logic [2:0]  wake_level_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] req_vec;
  // Raw requests in output bit order
  assign req_vec = {dac_ch2_req_in, dac_ch1_req_in, charge_time_unit_req_in,
    voltage_detect_req_in, uart_b_error_req_in, uart_a_error_req_in};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  ack_one_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  ack_on_take_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("request not acknowledged");
  prio_reset_a: assert property ($fell(sys_rst_in) |=>
    wake_level_out == 3'h4) else $error("priority not 4 after reset");
  wake_off_a: assert property (wake_level_out == 3'h0 &&
    $past(wake_level_out) == 3'h0 |-> !wake_req_out)
    else $error("wake request with priority zero");
  periph_gate_a: assert property (
    (periph_req_out & ~$past(req_vec, 3)) == 6'h00)
    else $error("peripheral request without source");
  wake_gate_a: assert property (wake_req_out |->
    $past(lowpower_wake_req_in, 3)) else $error("wake without source");
  prio_read_a: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in) == PRIO_OFS |-> wb_dat_out[31:3] == 29'h0)
    else $error("priority upper bits not zero");
  enable_read_a: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in) == ENABLE_OFS |-> wb_dat_out[31:16] == 16'h0 &&
    (wb_dat_out[15:0] & 16'h1ef9) == 16'h0) else $error("bad enable bits");
  cover property ($rose(irq_out));
  cover property (periph_req_out == 6'h3f);
  cover property (wake_req_out && wake_level_out == 3'h7);
endmodule : irq_slice_checker

// ---- dv/req_source_model.sv ----
// Peripheral request sources, prompt or one cycle slower
module req_source_model (
  input  wire logic       mclk_in,
  input  wire logic [6:0] pattern_in,
  input  wire logic       slow_in,
  output logic      [6:0] req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] stage_reg = 7'h00;
  // Requests change only just after a rising edge
  always @(posedge mclk_in) begin
    stage_reg <= pattern_in;
    req_out   <= slow_in ? stage_reg : pattern_in;
  end
endmodule : req_source_model

// ---- dv/tb_top.sv ----
module tb_top import irq_slice_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, slow_sel = 1'b0;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
  logic        wb_ack_out, wake_req_out, irq_out;
  logic [5:0]  periph_req_out;
  logic [2:0]  wake_level_out;
  logic [6:0]  src_pat = 7'h00, src_req;
  wire dac_ch2_req_in = src_req[6], dac_ch1_req_in = src_req[5];
  wire charge_time_unit_req_in = src_req[4];
  wire voltage_detect_req_in = src_req[3], uart_b_error_req_in = src_req[2];
  wire uart_a_error_req_in = src_req[1], lowpower_wake_req_in = src_req[0];
  int err_total = 0, tests_run = 0;
  int ebit[6] = '{1, 2, 8, 13, 14, 15};
  interrupt_enable_priority_slice interrupt_enable_priority_slice_i (.*);
  req_source_model req_source_model_i (.mclk_in(mclk_in),
    .pattern_in(src_pat), .slow_in(slow_sel), .req_out(src_req));
  initial forever #2 mclk_in = ~mclk_in;
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] rd);
    int n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_sel_in <= 4'h3;
    wb_dat_in <= dat;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge mclk_in);
  endtask : xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] r;
    xfer(1'b1, adr, dat, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, adr, 32'h0, r);
    chk(r, exp);
  endtask : rd_chk
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(wake_level_out, 3'h4);
    rd_chk(ENABLE_OFS, 32'h0);
    rd_chk(PRIO_OFS, 32'h4);
    rd_chk(8'h20, 32'h0);
    wr(ENABLE_OFS, 32'hffff_ffff);
    rd_chk(ENABLE_OFS, 32'h0000_e106);
    $display("test registers done");
    src_pat <= 7'h7f;
    repeat (6) @(posedge mclk_in);
    rd_chk(EVT_STAT_OFS, 32'h7f);
    chk(irq_out, 1'b0);
    wr(EVT_EN_OFS, 32'h7f);
    rd_chk(EVT_EN_OFS, 32'h7f);
    repeat (5) @(posedge mclk_in);
    chk(irq_out, 1'b1);
    wr(EVT_EN_OFS, 32'h0);
    repeat (5) @(posedge mclk_in);
    chk(irq_out, 1'b0);
    wr(EVT_EN_OFS, 32'h7f);
    wr(EVT_CLR_OFS, 32'h7f);
    repeat (5) @(posedge mclk_in);
    rd_chk(EVT_STAT_OFS, 32'h0);
    rd_chk(EVT_CLR_OFS, 32'h0);
    chk(irq_out, 1'b0);
    $display("test events done");
    slow_sel <= 1'b1;
    chk(periph_req_out, 6'h3f);
    foreach (ebit[i]) begin
      wr(ENABLE_OFS, 32'h1 << ebit[i]);
      repeat (5) @(posedge mclk_in);
      chk(periph_req_out, 6'h1 << i);
      rd_chk(PEND_OFS, 32'h1 << i);
    end
    $display("test gating done");
    for (int c = 0; c < 8; c++) begin
      wr(PRIO_OFS, 32'hfff8 | c);
      repeat (5) @(posedge mclk_in);
      rd_chk(PRIO_OFS, c);
      chk(wake_level_out, c);
      chk(wake_req_out, c != 0);
    end
    src_pat <= 7'h00;
    repeat (8) @(posedge mclk_in);
    chk(wake_req_out, 1'b0);
    chk(periph_req_out, 6'h00);
    rd_chk(PEND_OFS, 32'h0);
    $display("test priority done");
    end_sim();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    end_sim();
  end
endmodule : tb_top
bind interrupt_enable_priority_slice irq_slice_checker irq_slice_checker_i (.*);

// ---- hw/interrupt_enable_priority_slice.sv ----
// Function
// - Enable register holds bits 15,14,13,8,2,1 for six peripheral sources.
// - A set enable bit passes its request; a clear bit blocks it.
// - Priority register bits 2..0 hold wake-up priority; bits 15..3 absent.
// - Priority code 111 gives wake-up level 7, the highest.
// - Nonzero codes map directly to their numeric level, 001 lowest.
// - Priority code 000 blocks the wake-up request; its event status bit still sets.
// - Reset clears all enable bits and loads priority code 100.
module interrupt_enable_priority_slice
  import irq_slice_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        dac_ch2_req_in,
  input  wire logic        dac_ch1_req_in,
  input  wire logic        charge_time_unit_req_in,
  input  wire logic        voltage_detect_req_in,
  input  wire logic        uart_b_error_req_in,
  input  wire logic        uart_a_error_req_in,
  input  wire logic        lowpower_wake_req_in,
  output logic      [5:0]  periph_req_out,
  output logic             wake_req_out,
  output logic      [2:0]  wake_level_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] peripheral_irq_enable_4_reg;
  logic [2:0]  wakeup_irq_priority_reg;
  logic [6:0]  evt_stat_reg;
  logic [6:0]  evt_en_reg;
  logic [6:0]  req_sync1_reg;
  logic [6:0]  req_sync2_reg;
  logic [6:0]  req_prev_reg;
  bus_state_e  bus_state_reg;
  logic [5:0]  gated_req;
  logic [6:0]  raw_req;
  logic [6:0]  evt_rise;
  logic [6:0]  evt_clr;
  logic [31:0] rd_data;
  logic        bus_req;
  logic        wr_lo;
  logic        wr_hi;
  logic        rd_req;
  logic        enable_wr_lo;
  logic        enable_wr_hi;
  logic        prio_wr;
  logic        clr_wr;
  logic        evt_en_wr;
  logic        ack_next;
  bus_state_e  bus_state_next;
  logic [15:0] enable_next;
  logic [2:0]  prio_next;
  logic        wake_allowed;
  logic        wake_req_next;
  logic [2:0]  wake_level_next;
  logic [6:0]  evt_stat_next;
  logic [6:0]  evt_en_next;
  logic        irq_next;
  logic [15:0] enable_view;
  logic [2:0]  prio_view;

  // Gather the six enables into source order
  function automatic logic [5:0] pick_en(input logic [15:0] en);
    pick_en = {en[DAC2_BIT], en[DAC1_BIT], en[CTU_BIT],
               en[VDET_BIT], en[UARTB_BIT], en[UARTA_BIT]};
  endfunction : pick_en

  // Register select for one word offset
  function automatic logic reg_hit(input logic [7:0] adr,
                                   input logic [7:0] ofs);
    reg_hit = (adr == ofs);
  endfunction : reg_hit

  // Byte lane update that keeps absent positions at zero
  function automatic logic [7:0] lane_merge(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic [7:0] keep,
                                            input logic       wr);
    lane_merge = wr ? (new_val & keep) : old_val;
  endfunction : lane_merge

  // Arbitration level of a priority code; zero means no level at all
  function automatic logic [2:0] prio_level(input logic [2:0] code);
    if (code == PRIO_OFF) begin
      prio_level = PRIO_OFF;
    end else begin
      prio_level = code;
    end
  endfunction : prio_level

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // New request only while idle, so each access acks exactly once
  assign bus_req = wb_cyc_in && wb_stb_in && (bus_state_reg == BUS_IDLE);
  assign wr_lo   = bus_req && wb_we_in && wb_sel_in[0];
  assign wr_hi   = bus_req && wb_we_in && wb_sel_in[1];

  // Per-register strobes, all taken at the accepting edge
  assign enable_wr_lo = wr_lo && reg_hit(wb_adr_in, ENABLE_OFS);
  assign enable_wr_hi = wr_hi && reg_hit(wb_adr_in, ENABLE_OFS);
  assign prio_wr      = wr_lo && reg_hit(wb_adr_in, PRIO_OFS);
  assign clr_wr       = wr_lo && reg_hit(wb_adr_in, EVT_CLR_OFS);
  assign evt_en_wr    = wr_lo && reg_hit(wb_adr_in, EVT_EN_OFS);

  // Read request, seen once per access
  assign rd_req = bus_req && !wb_we_in;

  // Next handshake state: accept, then one ack cycle, then idle again
  always_comb begin
    bus_state_next = BUS_IDLE;
    ack_next       = 1'b0;
    case (bus_state_reg)
      BUS_IDLE: begin
        ack_next = bus_req;
        if (bus_req) begin
          bus_state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // Handshake state
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // One-cycle ack, dropped the cycle after it was given
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= ack_next;
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  // Writes touch only implemented positions, each byte lane under its own select
  always_comb begin
    enable_next[7:0]  = lane_merge(peripheral_irq_enable_4_reg[7:0],
                                   wb_dat_in[7:0], ENABLE_MASK[7:0],
                                   enable_wr_lo);
    enable_next[15:8] = lane_merge(peripheral_irq_enable_4_reg[15:8],
                                   wb_dat_in[15:8], ENABLE_MASK[15:8],
                                   enable_wr_hi);
  end

  // Enable storage, all clear at reset
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      peripheral_irq_enable_4_reg <= ENABLE_RESET;
    end else begin
      peripheral_irq_enable_4_reg <= enable_next;
    end
  end

  // Register as software reads it back
  assign enable_view = peripheral_irq_enable_4_reg & ENABLE_MASK;

  // ----------------------------------------------------------------
  // Wake-up priority register
  // ----------------------------------------------------------------
  // Three-bit field; the upper bits of the word are never stored
  always_comb begin
    prio_next = wakeup_irq_priority_reg;
    if (prio_wr) begin
      prio_next = wb_dat_in[PRIO_MSB:0];
    end
  end

  // Priority storage, level four at reset
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wakeup_irq_priority_reg <= PRIO_RESET;
    end else begin
      wakeup_irq_priority_reg <= prio_next;
    end
  end

  // Code zero keeps the wake-up source out of arbitration
  assign wake_allowed = (wakeup_irq_priority_reg != PRIO_OFF);

  // Level handed to the arbiter for the current code
  assign wake_level_next = prio_level(wakeup_irq_priority_reg);

  // Field as software reads it back
  assign prio_view = wakeup_irq_priority_reg;

  // ----------------------------------------------------------------
  // Request synchronisers
  // ----------------------------------------------------------------
  assign raw_req = {lowpower_wake_req_in, dac_ch2_req_in, dac_ch1_req_in,
                    charge_time_unit_req_in, voltage_detect_req_in,
                    uart_b_error_req_in, uart_a_error_req_in};

  // First stage; requests may be asynchronous, two stages before use
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_sync1_reg <= EVT_RESET;
    end else begin
      req_sync1_reg <= raw_req;
    end
  end

  // Second stage, the only reader of the first
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_sync2_reg <= EVT_RESET;
    end else begin
      req_sync2_reg <= req_sync1_reg;
    end
  end

  // Previous synchronised level, for edge detection
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_prev_reg <= EVT_RESET;
    end else begin
      req_prev_reg <= req_sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Gating toward arbitration
  // ----------------------------------------------------------------
  assign gated_req = req_sync2_reg[NUM_SRC-1:0] &
                     pick_en(peripheral_irq_enable_4_reg);
  assign wake_req_next = req_sync2_reg[NUM_SRC] && wake_allowed;

  // Gated peripheral requests to the arbiter
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      periph_req_out <= 6'h00;
    end else begin
      periph_req_out <= gated_req;
    end
  end

  // Wake-up request to the arbiter
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_req_out <= 1'b0;
    end else begin
      wake_req_out <= wake_req_next;
    end
  end

  // Level equals the code: 1 lowest, 7 highest
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_level_out <= PRIO_OFF;
    end else begin
      wake_level_out <= wake_level_next;
    end
  end

  // ----------------------------------------------------------------
  // Sticky event status with enable and write-one clear
  // ----------------------------------------------------------------
  // Rising edge of each synchronised request
  assign evt_rise = req_sync2_reg & ~req_prev_reg;

  // Write-one clear, only on an accepted write
  assign evt_clr  = clr_wr ? wb_dat_in[NUM_EVT-1:0] : EVT_RESET;

  // A new event wins over a clear in the same cycle
  assign evt_stat_next = (evt_stat_reg & ~evt_clr) | evt_rise;

  // Event status storage
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_stat_reg <= EVT_RESET;
    end else begin
      evt_stat_reg <= evt_stat_next;
    end
  end

  // Event interrupt enable, written as a whole
  assign evt_en_next = evt_en_wr ? wb_dat_in[NUM_EVT-1:0] : evt_en_reg;

  // Event enable storage
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_en_reg <= EVT_RESET;
    end else begin
      evt_en_reg <= evt_en_next;
    end
  end

  // Level interrupt from the status as it stands after this edge
  assign irq_next = |(evt_stat_next & evt_en_reg);

  // Level interrupt, registered
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped and write-only offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_in)
      ENABLE_OFS:   rd_data[15:0] = enable_view;
      PRIO_OFS:     rd_data[PRIO_MSB:0] = prio_view;
      EVT_STAT_OFS: rd_data[NUM_EVT-1:0] = evt_stat_reg;
      EVT_EN_OFS:   rd_data[NUM_EVT-1:0] = evt_en_reg;
      PEND_OFS:     rd_data[NUM_SRC-1:0] = gated_req;
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  // Read data latched with the ack
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (rd_req) begin
      wb_dat_out <= rd_data;
    end
  end

endmodule : interrupt_enable_priority_slice

// ---- hw/irq_slice_pkg.sv ----
package irq_slice_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ENABLE_OFS    = 8'h00;
  localparam logic [7:0]  PRIO_OFS      = 8'h04;
  localparam logic [7:0]  EVT_STAT_OFS  = 8'h08;
  localparam logic [7:0]  EVT_CLR_OFS   = 8'h0c;
  localparam logic [7:0]  EVT_EN_OFS    = 8'h10;
  localparam logic [7:0]  PEND_OFS      = 8'h14;

  // ----------------------------------------------------------------
  // Enable register fields
  // ----------------------------------------------------------------
  localparam int          DAC2_BIT      = 15;
  localparam int          DAC1_BIT      = 14;
  localparam int          CTU_BIT       = 13;
  localparam int          VDET_BIT      = 8;
  localparam int          UARTB_BIT     = 2;
  localparam int          UARTA_BIT     = 1;
  localparam logic [15:0] ENABLE_MASK   = 16'he106;
  localparam logic [15:0] ENABLE_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Priority register fields
  // ----------------------------------------------------------------
  localparam int          PRIO_MSB      = 2;
  localparam logic [2:0]  PRIO_RESET    = 3'h4;
  localparam logic [2:0]  PRIO_OFF      = 3'h0;

  // ----------------------------------------------------------------
  // Event status layout: one bit per source, wake-up at bit 6
  // ----------------------------------------------------------------
  localparam int          NUM_SRC       = 6;
  localparam int          NUM_EVT       = 7;
  localparam logic [6:0]  EVT_RESET     = 7'h00;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage : irq_slice_pkg
